//--- verilog/icrb_bank.sv
`timescale 1ns/10ps
`default_nettype none
module icrb_bank
	import icrb_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire icrb_pkg::icrb_req_t req,
	input wire logic [15:0] counter_value,
	input wire logic [7:0] error_in,
	input wire logic [7:0] status_in,
	output logic [31:0] rdata,
	output logic rvalid,
	output icrb_pkg::icrb_test_out_t test_out,
	output icrb_pkg::icrb_mode_out_t mode_out,
	output logic [31:0] data_wr,
	output logic [3:0] data_wr_be,
	output logic data_wr_stb,
	output logic [7:0] sector_num,
	output logic [7:0] sector_cnt,
	output logic [7:0] features,
	output logic [7:0] command,
	output logic command_stb,
	output logic [7:0] dev_head,
	output logic [7:0] cyl_high,
	output logic [7:0] cyl_low
);
	import icrb_pkg::*;

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function automatic logic lone_be(input logic [3:0] be, input int lane);
		lone_be = (be == 4'(1 << lane));
	endfunction

	function automatic logic data_be_ok(input logic [3:0] be);
		data_be_ok = (be == BE_BYTE) || (be == BE_HALF) || (be == BE_WORD);
	endfunction

	function automatic logic [31:0] be_mask(input logic [3:0] be);
		be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	// Valid targets of the test selector
	function automatic logic target_ok(input logic [3:0] m, input logic [7:0] s, input logic [3:0] n);
		logic ok;
		ok = 1'b0;
		unique case (m)
			MOD_DATA_INTERFACE: ok = (s == SUB_FIFO_DATA);
			MOD_TIMER: ok = (s >= SUB_TIMER1) && (s <= SUB_TIMER4);
			MOD_BUS_INTERFACE: ok = (s == SUB_BYTE_COUNT) || (s == SUB_WATCHDOG);
			MOD_ULTRA_WRITE: ok = (s == SUB_ULTRA_TIMER);
			default: ok = 1'b0;
		endcase
		target_ok = ok && ($countones(n) == 1);
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [31:0] test_q, test_d;
	logic [1:0] drv0_q, drv0_d, drv1_q, drv1_d;
	logic [7:0] sec_q, sec_d, cnt_q, cnt_d, feat_q, feat_d;
	logic [7:0] cmd_q, cmd_d, head_q, head_d, ch_q, ch_d, cl_q, cl_d;
	logic [31:0] rdata_q, rdata_d, dwr_q, dwr_d;
	logic rvalid_q, rvalid_d, load_q, load_d, dstb_q, dstb_d, cstb_q, cstb_d;
	logic [3:0] dbe_q, dbe_d;
	logic iordy0_q, iordy0_d, iordy1_q, iordy1_d;

	logic hit_test, hit_mode, hit_low, hit_high, tgt_ok;

	always_comb
	begin
		hit_test = (req.addr == OFS_COUNTER_TEST);
		hit_mode = (req.addr == OFS_TRANSFER_MODE);
		hit_low = (req.addr == OFS_TASKFILE_LOW);
		hit_high = (req.addr == OFS_TASKFILE_HIGH);
		tgt_ok = target_ok(test_q[MOD_SEL_LSB +: 4], test_q[SUB_SEL_LSB +: 8], test_q[NIB_SEL_LSB +: 4]);
	end

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb
	begin
		test_d = test_q;
		drv0_d = drv0_q;
		drv1_d = drv1_q;
		sec_d = sec_q;
		cnt_d = cnt_q;
		feat_d = feat_q;
		cmd_d = cmd_q;
		head_d = head_q;
		ch_d = ch_q;
		cl_d = cl_q;
		rdata_d = rdata_q;
		rvalid_d = 1'b0;
		load_d = 1'b0;
		dwr_d = dwr_q;
		dbe_d = dbe_q;
		dstb_d = 1'b0;
		cstb_d = 1'b0;
		if (req.wr)
		begin
			if (hit_test)
			begin
				// Selector bytes follow byte enables like any plain register
				test_d = (test_q & ~be_mask(req.be)) | (req.wdata & be_mask(req.be));
				load_d = |req.be[1:0];
			end
			if (hit_mode && req.be[0])
			begin
				drv1_d = req.wdata[DRV1_MODE_LSB +: 2];
				drv0_d = req.wdata[DRV0_MODE_LSB +: 2];
			end
			if (hit_low)
			begin
				if (lone_be(req.be, 3))
					sec_d = req.wdata[31:24];
				else if (lone_be(req.be, 2))
					cnt_d = req.wdata[23:16];
				else if (lone_be(req.be, 1))
					feat_d = req.wdata[15:8];
				else if (data_be_ok(req.be))
				begin
					dwr_d = req.wdata & be_mask(req.be);
					dbe_d = req.be;
					dstb_d = 1'b1;
				end
			end
			if (hit_high)
			begin
				// Any multi-lane pattern is dropped whole
				if (lone_be(req.be, 3))
				begin
					cmd_d = req.wdata[31:24];
					cstb_d = 1'b1;
				end
				else if (lone_be(req.be, 2))
					head_d = req.wdata[23:16];
				else if (lone_be(req.be, 1))
					ch_d = req.wdata[15:8];
				else if (lone_be(req.be, 0))
					cl_d = req.wdata[7:0];
			end
		end
		if (req.rd)
		begin
			rvalid_d = 1'b1;
			rdata_d = 32'h0000_0000;
			if (hit_test)
				rdata_d = {test_q[31:16], tgt_ok ? counter_value : 16'h0000} & be_mask(req.be);
			else if (hit_mode)
				rdata_d = {24'h000000, 2'h0, drv1_q, 2'h0, drv0_q} & be_mask(req.be);
			else if (hit_low)
			begin
				if (lone_be(req.be, 3))
					rdata_d = {sec_q, 24'h000000};
				else if (lone_be(req.be, 2))
					rdata_d = {8'h00, cnt_q, 16'h0000};
				else if (lone_be(req.be, 1))
					rdata_d = {16'h0000, error_in, 8'h00};
				else
					rdata_d = 32'h0000_0000;
			end
			else if (hit_high)
			begin
				if (lone_be(req.be, 3))
					rdata_d = {status_in, 24'h000000};
				else if (lone_be(req.be, 2))
					rdata_d = {8'h00, head_q, 16'h0000};
				else if (lone_be(req.be, 1))
					rdata_d = {16'h0000, ch_q, 8'h00};
				else if (lone_be(req.be, 0))
					rdata_d = {24'h000000, cl_q};
				else
					rdata_d = 32'h0000_0000;
			end
		end
		// Flags stored beside the mode so the port comes straight from a flop
		iordy1_d = |drv1_d;
		iordy0_d = |drv0_d;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			test_q <= RST_COUNTER_TEST;
			drv1_q <= RST_TRANSFER_MODE[DRV1_MODE_LSB +: 2];
			drv0_q <= RST_TRANSFER_MODE[DRV0_MODE_LSB +: 2];
			sec_q <= RST_TASKFILE[31:24];
			cnt_q <= RST_TASKFILE[23:16];
			feat_q <= RST_TASKFILE[15:8];
			cmd_q <= RST_TASKFILE[31:24];
			head_q <= RST_TASKFILE[23:16];
			ch_q <= RST_TASKFILE[15:8];
			cl_q <= RST_TASKFILE[7:0];
			rdata_q <= 32'h0000_0000;
			rvalid_q <= 1'b0;
			load_q <= 1'b0;
			dwr_q <= 32'h0000_0000;
			dbe_q <= 4'h0;
			dstb_q <= 1'b0;
			cstb_q <= 1'b0;
			iordy1_q <= |RST_TRANSFER_MODE[DRV1_MODE_LSB +: 2];
			iordy0_q <= |RST_TRANSFER_MODE[DRV0_MODE_LSB +: 2];
		end
		else
		begin
			test_q <= test_d;
			drv1_q <= drv1_d;
			drv0_q <= drv0_d;
			sec_q <= sec_d;
			cnt_q <= cnt_d;
			feat_q <= feat_d;
			cmd_q <= cmd_d;
			head_q <= head_d;
			ch_q <= ch_d;
			cl_q <= cl_d;
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
			load_q <= load_d;
			dwr_q <= dwr_d;
			dbe_q <= dbe_d;
			dstb_q <= dstb_d;
			cstb_q <= cstb_d;
			iordy1_q <= iordy1_d;
			iordy0_q <= iordy0_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign rdata = rdata_q;
	assign rvalid = rvalid_q;
	assign test_out = '{module_sel: test_q[MOD_SEL_LSB +: 4], sub_sel: test_q[SUB_SEL_LSB +: 8],
		data: test_q[15:0], load: load_q};
	assign mode_out = '{drv1: icrb_mode_t'(drv1_q), drv0: icrb_mode_t'(drv0_q),
		iordy1: iordy1_q, iordy0: iordy0_q};
	assign data_wr = dwr_q;
	assign data_wr_be = dbe_q;
	assign data_wr_stb = dstb_q;
	assign sector_num = sec_q;
	assign sector_cnt = cnt_q;
	assign features = feat_q;
	assign command = cmd_q;
	assign command_stb = cstb_q;
	assign dev_head = head_q;
	assign cyl_high = ch_q;
	assign cyl_low = cl_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_iordy;
		@(posedge clk) disable iff (sys_rst) mode_out.iordy0 == (mode_out.drv0 != ICRB_PIO_NO_IORDY);
	endproperty
	a_iordy: assert property (p_iordy) else $error("iordy flag wrong");

	property p_mode_rsv;
		@(posedge clk) disable iff (sys_rst) (req.rd && hit_mode) |=> (rdata[31:6] == 26'h0) && (rdata[3:2] == 2'h0);
	endproperty
	a_mode_rsv: assert property (p_mode_rsv) else $error("reserved bits nonzero");

	property p_mode_wr;
		@(posedge clk) disable iff (sys_rst) (req.wr && hit_mode && req.be[0]) |=>
			(mode_out.drv1 == $past(req.wdata[5:4])) && (mode_out.drv0 == $past(req.wdata[1:0]));
	endproperty
	a_mode_wr: assert property (p_mode_wr) else $error("mode not stored");

	property p_bad_be;
		@(posedge clk) disable iff (sys_rst) (req.rd && hit_high && $countones(req.be) != 1) |=> rdata == 32'h0;
	endproperty
	a_bad_be: assert property (p_bad_be) else $error("illegal enables read nonzero");

	property p_high_stable;
		@(posedge clk) disable iff (sys_rst) (req.wr && hit_high && $countones(req.be) != 1) |=>
			$stable(cl_q) && $stable(ch_q) && $stable(head_q) && !command_stb;
	endproperty
	a_high_stable: assert property (p_high_stable) else $error("illegal write changed register");

	property p_cmd;
		@(posedge clk) disable iff (sys_rst) (req.wr && hit_high && req.be == 4'h8) |=>
			command_stb && command == $past(req.wdata[31:24]);
	endproperty
	a_cmd: assert property (p_cmd) else $error("command not captured");

	property p_feat;
		@(posedge clk) disable iff (sys_rst) (req.rd && hit_low && req.be == 4'h2) |=> rdata[15:8] == $past(error_in);
	endproperty
	a_feat: assert property (p_feat) else $error("error byte not returned");

	property p_data;
		@(posedge clk) disable iff (sys_rst) (req.wr && hit_low && req.be == BE_HALF) |=>
			data_wr_stb && data_wr == {16'h0, $past(req.wdata[15:0])};
	endproperty
	a_data: assert property (p_data) else $error("data port wrong");

	property p_load;
		@(posedge clk) disable iff (sys_rst) (req.wr && hit_test && req.be[0]) |=>
			test_out.load && test_out.data[7:0] == $past(req.wdata[7:0]);
	endproperty
	a_load: assert property (p_load) else $error("preload wrong");

	property p_sec;
		@(posedge clk) disable iff (sys_rst) (req.wr && hit_low && req.be == 4'h8) |=> sector_num == $past(req.wdata[31:24]);
	endproperty
	a_sec: assert property (p_sec) else $error("sector not stored");
endmodule
`default_nettype wire

//--- verilog/icrb_pkg.sv
package icrb_pkg;
	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFS_COUNTER_TEST = 8'hB0;
	localparam logic [7:0] OFS_TRANSFER_MODE = 8'hB4;
	localparam logic [7:0] OFS_TASKFILE_LOW = 8'hC0;
	localparam logic [7:0] OFS_TASKFILE_HIGH = 8'hC4;

	// ----------------------------------------
	// Reset values and fields
	// ----------------------------------------
	localparam logic [31:0] RST_COUNTER_TEST = 32'h0000_0000;
	localparam logic [31:0] RST_TRANSFER_MODE = 32'h0000_0022;
	localparam logic [31:0] RST_TASKFILE = 32'h0000_0000;
	localparam int MOD_SEL_LSB = 28;
	localparam int NIB_SEL_LSB = 24;
	localparam int SUB_SEL_LSB = 16;
	localparam int DRV1_MODE_LSB = 4;
	localparam int DRV0_MODE_LSB = 0;

	// ----------------------------------------
	// Module and sub-module codes
	// ----------------------------------------
	localparam logic [3:0] MOD_DATA_INTERFACE = 4'h1;
	localparam logic [3:0] MOD_TIMER = 4'h2;
	localparam logic [3:0] MOD_BUS_INTERFACE = 4'h3;
	localparam logic [3:0] MOD_ULTRA_WRITE = 4'h4;
	localparam logic [7:0] SUB_FIFO_DATA = 8'h01;
	localparam logic [7:0] SUB_TIMER1 = 8'h01;
	localparam logic [7:0] SUB_TIMER4 = 8'h04;
	localparam logic [7:0] SUB_BYTE_COUNT = 8'h01;
	localparam logic [7:0] SUB_WATCHDOG = 8'h02;
	localparam logic [7:0] SUB_ULTRA_TIMER = 8'h01;
	localparam logic [7:0] NIB_LSN = 8'h01;

	// ----------------------------------------
	// Byte-enable patterns (active high)
	// ----------------------------------------
	localparam logic [3:0] BE_BYTE = 4'h1;
	localparam logic [3:0] BE_HALF = 4'h3;
	localparam logic [3:0] BE_WORD = 4'hF;

	// ----------------------------------------
	// Transfer mode encodings
	// ----------------------------------------
	typedef enum logic [1:0] {
		ICRB_PIO_NO_IORDY = 2'h0,
		ICRB_PIO_IORDY = 2'h1,
		ICRB_DMA = 2'h2,
		ICRB_ULTRA_DMA = 2'h3
	} icrb_mode_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} icrb_req_t;

	typedef struct packed {
		icrb_mode_t drv1;
		icrb_mode_t drv0;
		logic iordy1;
		logic iordy0;
	} icrb_mode_out_t;

	typedef struct packed {
		logic [3:0] module_sel;
		logic [7:0] sub_sel;
		logic [15:0] data;
		logic load;
	} icrb_test_out_t;
endpackage

//--- tb/icrb_host.sv
`timescale 1ns/10ps
`default_nettype none
module icrb_host
(
	input wire logic clk,
	output icrb_pkg::icrb_req_t req,
	input wire logic [31:0] rdata,
	input wire logic rvalid
);
	import icrb_pkg::*;
	// ----------------------------------------
	// Host access tasks
	// ----------------------------------------
	initial req = '0;

	// Idle lines carry inverted junk so a stale value never looks live
	task automatic drop();
		icrb_req_t r;
		r = ~req;
		r.wr = 1'b0;
		r.rd = 1'b0;
		req <= r;
	endtask

	task automatic write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		@(negedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, be: be, wdata: d};
		@(negedge clk);
		drop();
	endtask

	task automatic read(input logic [7:0] a, input logic [3:0] be, output logic [31:0] d, output logic v);
		@(negedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, be: be, wdata: ~req.wdata};
		@(negedge clk);
		drop();
		d = rdata;
		v = rvalid;
	endtask
endmodule
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import icrb_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [15:0] counter_value = 16'h0000;
	logic [7:0] error_in = 8'h00;
	logic [7:0] status_in = 8'h00;
	icrb_req_t req;
	logic [31:0] rdata;
	logic [31:0] data_wr;
	logic [31:0] w;
	logic [31:0] m;
	logic [3:0] data_wr_be;
	logic [3:0] be;
	logic [1:0] md;
	logic rvalid;
	logic data_wr_stb;
	logic command_stb;
	icrb_test_out_t test_out;
	icrb_mode_out_t mode_out;
	logic [7:0] sector_num, sector_cnt, features, command, dev_head, cyl_high, cyl_low;
	int miscompares = 0;
	int compares = 0;
	int cycles = 0;
	logic [11:0] sel [8] = '{12'h101, 12'h201, 12'h202, 12'h203, 12'h204, 12'h301, 12'h302, 12'h401};
	logic [31:0] bad [3] = '{32'h1301_0000, 32'h5101_0000, 32'h2105_0000};
	logic [3:0] bes [3] = '{BE_BYTE, BE_HALF, BE_WORD};

	always #4 clk = ~clk;

	icrb_host host (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));

	icrb_bank DUT (.clk(clk), .sys_rst(sys_rst), .req(req), .counter_value(counter_value),
		.error_in(error_in), .status_in(status_in), .rdata(rdata), .rvalid(rvalid),
		.test_out(test_out), .mode_out(mode_out), .data_wr(data_wr), .data_wr_be(data_wr_be),
		.data_wr_stb(data_wr_stb), .sector_num(sector_num), .sector_cnt(sector_cnt),
		.features(features), .command(command), .command_stb(command_stb), .dev_head(dev_head),
		.cyl_high(cyl_high), .cyl_low(cyl_low));

	// ----------------------------------------
	// Checking and closing
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [3:0] b, input logic [31:0] exp);
		logic [31:0] d;
		logic v;
		host.read(a, b, d, v);
		chk({31'h0, v}, 32'h1);
		chk(d, exp);
	endtask

	function automatic logic [31:0] lanes(input logic [3:0] b);
		return {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
	endfunction

	task automatic test_done();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Whole sequence needs well under a thousand cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			miscompares++;
			test_done();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (5) @(negedge clk);
		sys_rst = 1'b0;
		rchk(OFS_TRANSFER_MODE, BE_WORD, RST_TRANSFER_MODE);
		chk({26'h0, mode_out}, 32'h2B);
		rchk(OFS_COUNTER_TEST, BE_WORD, RST_COUNTER_TEST);
		rchk(8'hB8, BE_WORD, 32'h0);
		for (int i = 0; i < 4; i++)
		begin
			md = 2'(i);
			host.write(OFS_TRANSFER_MODE, BE_WORD, {24'hFFFFFF, 2'h3, md, 2'h3, ~md});
			rchk(OFS_TRANSFER_MODE, BE_WORD, {26'h0, md, 2'h0, ~md});
			chk({26'h0, mode_out}, {26'h0, md, ~md, |md, |(~md)});
		end
		for (int i = 0; i < 8; i++)
		begin
			w = {sel[i][11:8], 4'(4'h1 << (i % 4)), sel[i][7:0], 16'(16'hA500 + i)};
			host.write(OFS_COUNTER_TEST, BE_WORD, w);
			chk({3'h0, test_out}, {3'h0, w[31:28], w[23:0], 1'b1});
			counter_value = 16'(16'h5A00 + i);
			rchk(OFS_COUNTER_TEST, BE_WORD, {w[31:16], counter_value});
		end
		for (int i = 0; i < 3; i++)
		begin
			host.write(OFS_COUNTER_TEST, BE_WORD, bad[i]);
			rchk(OFS_COUNTER_TEST, BE_WORD, bad[i]);
		end
		error_in = 8'h44;
		status_in = 8'h5E;
		for (int j = 0; j < 8; j++)
		begin
			be = 4'(4'h1 << (j % 4));
			if (j > 0)
			begin
				m = (j < 4) ? 32'h1122_3344 : 32'h9C77_6655;
				host.write((j < 4) ? OFS_TASKFILE_LOW : OFS_TASKFILE_HIGH, be, m);
			end
		end
		chk({sector_num, sector_cnt, features, 8'h0}, 32'h1122_3300);
		chk({command, dev_head, cyl_high, cyl_low}, 32'h9C77_6655);
		host.write(OFS_TASKFILE_HIGH, BE_BYTE, 32'h0000_0055);
		host.write(OFS_TASKFILE_HIGH, 4'h8, 32'hA100_0000);
		chk({23'h0, command_stb, command}, 32'h1A1);
		host.write(OFS_TASKFILE_LOW, 4'h6, 32'hFFFF_FFFF);
		host.write(OFS_TASKFILE_HIGH, 4'h3, 32'hFFFF_FFFF);
		chk({sector_cnt, features, dev_head, cyl_low}, 32'h2233_7755);
		rchk(OFS_TASKFILE_LOW, 4'h2, 32'h0000_4400);
		rchk(OFS_TASKFILE_LOW, 4'h4, 32'h0022_0000);
		rchk(OFS_TASKFILE_LOW, 4'h8, 32'h1100_0000);
		rchk(OFS_TASKFILE_HIGH, 4'h8, 32'h5E00_0000);
		rchk(OFS_TASKFILE_HIGH, 4'h4, 32'h0077_0000);
		rchk(OFS_TASKFILE_HIGH, 4'h2, 32'h0000_6600);
		rchk(OFS_TASKFILE_HIGH, 4'h1, 32'h0000_0055);
		rchk(OFS_TASKFILE_LOW, 4'h6, 32'h0);
		rchk(OFS_TASKFILE_HIGH, 4'h3, 32'h0);
		for (int k = 0; k < 3; k++)
		begin
			host.write(OFS_TASKFILE_LOW, bes[k], 32'hDEAD_BEEF);
			chk(data_wr & lanes(bes[k]), 32'hDEAD_BEEF & lanes(bes[k]));
			chk({27'h0, data_wr_stb, data_wr_be}, {27'h0, 1'b1, bes[k]});
		end
		// Second reset mid-run: mode, counter test, sector count, features, head and cylinder low must fall back to reset values
		sys_rst = 1'b1;
		@(negedge clk);
		sys_rst = 1'b0;
		rchk(OFS_TRANSFER_MODE, BE_WORD, RST_TRANSFER_MODE);
		chk({26'h0, mode_out}, 32'h2B);
		rchk(OFS_COUNTER_TEST, BE_WORD, RST_COUNTER_TEST);
		chk({sector_cnt, features, dev_head, cyl_low}, RST_TASKFILE);
		test_done();
	end
endmodule
`default_nettype wire
